//--- far_side_model.sv
// Purpose: far side of the pins, source levels and routable clocks
// Assumes: bench commands flag levels and the level of undriven pads
// Notes: routable sources toggle from a free running counter
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
	input  wire logic                            clock,
	input  wire pinmux_pkg::flag_src_type        flag_cmd,
	input  wire logic [1:0]                      pad_level,
	input  wire pinmux_pkg::pin_drive_type [1:0] mic_drive,
	output wire pinmux_pkg::flag_src_type        flag_src,
	output wire pinmux_pkg::out_src_type         out_src,
	output wire logic [1:0]                      mic_pin_in
);
	logic [4:0] cnt_q = 5'h00;
	always_ff @(posedge clock)
		cnt_q <= cnt_q + 5'h01;
	assign flag_src = flag_cmd;
	assign out_src = {cnt_q[0], cnt_q[1], cnt_q[2], ~cnt_q[0], cnt_q[3]};
	// pad follows the device while it drives
	assign mic_pin_in[0] = mic_drive[0].oe_n ? pad_level[0] : mic_drive[0].out;
	assign mic_pin_in[1] = mic_drive[1].oe_n ? pad_level[1] : mic_drive[1].out;
endmodule
`default_nettype wire

//--- multifunction_pin_and_irq2_control.sv
// Purpose: pin function select for two microphone pins and the serial out pin,
//          sticky interrupt flags and two pulsed interrupt lines
// Assumes: register port strobes are single cycle pulses, sources synchronous
// Notes: read data is valid the cycle after reg_rd
// Notes on behaviour
// - noise enable bit adds agc noise events to second interrupt line
// - engine bit adds engine interrupts and overflow flags to second line
// - data-available bit adds converter data-available events to second line
// - single mode gives one active high pulse of 2 ms per event
// - repeat mode pulses 2 ms every 4 ms until flag register read
// - mic clock pin code 0 powers down input and output buffers
// - code 1 makes mic clock pin an input for core use
// - code 2 samples pin level into read-only bit 1
// - code 3 drives mic clock pin from bit 0
// - codes 4,5,6 route divided clock, first and second interrupt lines
// - codes 8,9,10 route secondary bit clock, word clock, modulator clock
// - mic data pin has same codes in its own register
// - mic data pin code 3 drives bit 0 level
// - serial out field resets to primary data, code 0 powers buffer down
// - serial out codes 2 to 7 select gpo, clock, irqs, secondary clocks
// - serial out code 2 drives bit 0 level
// - keeper bit 4 enables bus keeper when 0, resets to 1
// - flags are sticky, clear on read, set again on fresh source
// - first interrupt line has same enables and modes at its own register
`timescale 1ns/100ps
`default_nettype none
module multifunction_pin_and_irq2_control #(
	parameter int unsigned pulse_high_cycles = pinmux_pkg::PULSE_HIGH_CYC,
	parameter int unsigned pulse_low_cycles  = pinmux_pkg::PULSE_LOW_CYC
) (
	input  wire logic                      clock,
	input  wire logic                      rstn,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [6:0]                reg_addr,
	input  wire logic [7:0]                reg_wdata,
	output var  logic [7:0]                reg_rdata,
	input  wire pinmux_pkg::flag_src_type  flag_src,
	input  wire pinmux_pkg::out_src_type   out_src,
	input  wire logic [1:0]                mic_pin_in,
	output var  pinmux_pkg::pin_drive_type [1:0] mic_drive,
	output var  logic [1:0]                mic_core_in,
	output var  pinmux_pkg::pin_drive_type dout_drive,
	output var  logic                      dout_keeper_en,
	output wire logic [1:0]                irq_line
);
	localparam logic [pinmux_pkg::CNT_W-1:0] HIGH_LAST =
		pinmux_pkg::CNT_W'(pulse_high_cycles - 1);
	localparam logic [pinmux_pkg::CNT_W-1:0] LOW_LAST =
		pinmux_pkg::CNT_W'(pulse_low_cycles - 1);

	logic [7:0]                  irq_ctl_q [2];
	logic [7:0]                  mic_q [2];
	logic [7:0]                  dout_q;
	logic [1:0]                  gpi_q;
	logic [7:0]                  src_q;
	logic [2:0]                  ovf_q;
	logic [3:0]                  adc_q;
	logic [7:0]                  rdata_q;
	logic                        rpt_q [2];
	pinmux_pkg::pulse_state_type st_q [2];
	pinmux_pkg::pulse_state_type st_d [2];
	logic [pinmux_pkg::CNT_W-1:0] cnt_q [2];
	logic [pinmux_pkg::CNT_W-1:0] cnt_d [2];
	logic [1:0]                  trig;
	logic [1:0]                  dout_sel_out;

	wire logic [7:0] src_rise = flag_src & ~src_q;
	wire logic       rd_ovf = reg_rd && reg_addr == pinmux_pkg::OFF_FLAG_OVF;
	wire logic       rd_adc = reg_rd && reg_addr == pinmux_pkg::OFF_FLAG_ADC;
	wire logic       flag_rd = rd_ovf || rd_adc;
	wire logic [2:0] ovf_ev = src_rise[7:5];
	wire logic [3:0] adc_ev = src_rise[4:1];
	wire logic       noise_ev = |adc_ev[3:2];
	wire logic       eng_ev = (|adc_ev[1:0]) || (|ovf_ev);
	wire logic       da_ev = src_rise[0];
	wire logic [7:0] rd_mux =
		rd_ovf ? {4'h0, ovf_q, 1'b0} :
		rd_adc ? {1'b0, adc_q, 3'h0} :
		reg_addr == pinmux_pkg::OFF_IRQ1_CTL ? irq_ctl_q[0] :
		reg_addr == pinmux_pkg::OFF_IRQ2_CTL ? irq_ctl_q[1] :
		reg_addr == pinmux_pkg::OFF_MIC_CLK ? {mic_q[0][7:2], gpi_q[0], mic_q[0][0]} :
		reg_addr == pinmux_pkg::OFF_MIC_DAT ? {mic_q[1][7:2], gpi_q[1], mic_q[1][0]} :
		reg_addr == pinmux_pkg::OFF_DOUT ? dout_q : 8'h00;
	wire pinmux_pkg::dout_code_type dout_code = pinmux_pkg::dout_code_type'(dout_q[3:1]);

	assign reg_rdata = rdata_q;

	// sticky flags, a fresh source edge wins over the clearing read
	always_ff @(posedge clock) begin
		if (!rstn) begin
			src_q <= 8'h00;
			ovf_q <= 3'h0;
			adc_q <= 4'h0;
			rdata_q <= 8'h00;
		end else begin
			src_q <= flag_src;
			ovf_q <= (ovf_q & {3{~rd_ovf}}) | ovf_ev;
			adc_q <= (adc_q & {4{~rd_adc}}) | adc_ev;
			if (reg_rd) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// control registers, reserved bits never take written ones
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_ctl_q[0] <= pinmux_pkg::IRQ_CTL_RST;
			irq_ctl_q[1] <= pinmux_pkg::IRQ_CTL_RST;
			mic_q[0] <= pinmux_pkg::MIC_RST;
			mic_q[1] <= pinmux_pkg::MIC_RST;
			dout_q <= pinmux_pkg::DOUT_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				pinmux_pkg::OFF_IRQ1_CTL: irq_ctl_q[0] <= reg_wdata & pinmux_pkg::IRQ_CTL_WMASK;
				pinmux_pkg::OFF_IRQ2_CTL: irq_ctl_q[1] <= reg_wdata & pinmux_pkg::IRQ_CTL_WMASK;
				pinmux_pkg::OFF_MIC_CLK: mic_q[0] <= reg_wdata & pinmux_pkg::MIC_WMASK;
				pinmux_pkg::OFF_MIC_DAT: mic_q[1] <= reg_wdata & pinmux_pkg::MIC_WMASK;
				pinmux_pkg::OFF_DOUT: dout_q <= reg_wdata & pinmux_pkg::DOUT_WMASK;
				default: ;
			endcase
		end
	end

	// interrupt pulse generators, index 0 first line, index 1 second line
	for (genvar g = 0; g < 2; g++) begin : gen_irq
		assign trig[g] = (irq_ctl_q[g][pinmux_pkg::IRQ_NOISE_BIT] && noise_ev) ||
			(irq_ctl_q[g][pinmux_pkg::IRQ_ENG_BIT] && eng_ev) ||
			(irq_ctl_q[g][pinmux_pkg::IRQ_DA_BIT] && da_ev);
		assign irq_line[g] = st_q[g] == pinmux_pkg::PS_HIGH;
		wire logic rpt_d = trig[g] || (rpt_q[g] && !flag_rd);

		always_comb begin
			st_d[g] = st_q[g];
			cnt_d[g] = cnt_q[g] + 1'b1;
			case (st_q[g])
				pinmux_pkg::PS_IDLE: begin
					cnt_d[g] = '0;
					if (trig[g]) begin
						st_d[g] = pinmux_pkg::PS_HIGH;
					end
				end
				pinmux_pkg::PS_HIGH: begin
					if (cnt_q[g] == HIGH_LAST) begin
						cnt_d[g] = '0;
						if (irq_ctl_q[g][pinmux_pkg::IRQ_RPT_BIT] && rpt_d) begin
							st_d[g] = pinmux_pkg::PS_LOW;
						end else begin
							st_d[g] = pinmux_pkg::PS_IDLE;
						end
					end
				end
				pinmux_pkg::PS_LOW: begin
					if (!rpt_d) begin
						st_d[g] = pinmux_pkg::PS_IDLE;
					end else if (cnt_q[g] == LOW_LAST) begin
						cnt_d[g] = '0;
						st_d[g] = pinmux_pkg::PS_HIGH;
					end
				end
				default: begin
					st_d[g] = pinmux_pkg::PS_IDLE;
					cnt_d[g] = '0;
				end
			endcase
		end

		always_ff @(posedge clock) begin
			if (!rstn) begin
				st_q[g] <= pinmux_pkg::PS_IDLE;
				cnt_q[g] <= '0;
				rpt_q[g] <= 1'b0;
			end else begin
				st_q[g] <= st_d[g];
				cnt_q[g] <= cnt_d[g];
				rpt_q[g] <= rpt_d;
			end
		end
	end

	// microphone pins, index 0 clock pin, index 1 data pin
	for (genvar g = 0; g < 2; g++) begin : gen_mic
		wire pinmux_pkg::mic_code_type code = pinmux_pkg::mic_code_type'(mic_q[g][5:2]);
		wire logic in_en = code == pinmux_pkg::MIC_IN || code == pinmux_pkg::MIC_GPI;
		logic sel_out;
		logic out_en;

		always_comb begin
			sel_out = 1'b0;
			out_en = 1'b1;
			case (code)
				pinmux_pkg::MIC_GPO: sel_out = mic_q[g][pinmux_pkg::GPO_BIT];
				pinmux_pkg::MIC_DIVIDED_CLOCK_OUTPUT: sel_out = out_src.divided_clock_output;
				pinmux_pkg::MIC_IRQ1: sel_out = irq_line[0];
				pinmux_pkg::MIC_IRQ2: sel_out = irq_line[1];
				pinmux_pkg::MIC_BCLK: sel_out = out_src.sec_bclk;
				pinmux_pkg::MIC_WCLK: sel_out = out_src.sec_wclk;
				pinmux_pkg::MIC_MODCLK: sel_out = out_src.mod_clk;
				default: out_en = 1'b0;
			endcase
		end

		always_ff @(posedge clock) begin
			if (!rstn) begin
				mic_drive[g] <= '{out: 1'b0, oe_n: 1'b1, in_en: 1'b0, out_en: 1'b0};
				gpi_q[g] <= 1'b0;
				mic_core_in[g] <= 1'b0;
			end else begin
				mic_drive[g] <= '{out: sel_out, oe_n: ~out_en, in_en: in_en, out_en: out_en};
				gpi_q[g] <= (code == pinmux_pkg::MIC_GPI) && mic_pin_in[g];
				mic_core_in[g] <= (code == pinmux_pkg::MIC_IN) && mic_pin_in[g];
			end
		end
	end

	// serial out pin
	always_comb begin
		dout_sel_out = 2'b10;
		case (dout_code)
			pinmux_pkg::DOUT_OFF: dout_sel_out = 2'b00;
			pinmux_pkg::DOUT_PRI: dout_sel_out[0] = out_src.pri_dout;
			pinmux_pkg::DOUT_GPO: dout_sel_out[0] = dout_q[pinmux_pkg::GPO_BIT];
			pinmux_pkg::DOUT_DIVIDED_CLOCK_OUTPUT: dout_sel_out[0] = out_src.divided_clock_output;
			pinmux_pkg::DOUT_IRQ1: dout_sel_out[0] = irq_line[0];
			pinmux_pkg::DOUT_IRQ2: dout_sel_out[0] = irq_line[1];
			pinmux_pkg::DOUT_BCLK: dout_sel_out[0] = out_src.sec_bclk;
			pinmux_pkg::DOUT_WCLK: dout_sel_out[0] = out_src.sec_wclk;
			default: dout_sel_out = 2'b00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			dout_drive <= '{out: 1'b0, oe_n: 1'b1, in_en: 1'b0, out_en: 1'b0};
			dout_keeper_en <= 1'b0;
		end else begin
			dout_drive <= '{out: dout_sel_out[0], oe_n: ~dout_sel_out[1], in_en: 1'b0,
				out_en: dout_sel_out[1]};
			dout_keeper_en <= ~dout_q[pinmux_pkg::KEEP_BIT];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_flag_read;
		flag_rd && !trig[1] ##1 !trig[1];
	endsequence
	sequence s_repeat_off;
		!rpt_q[1] && st_q[1] != pinmux_pkg::PS_LOW;
	endsequence

	noise_source_a: assert property (st_q[1] == pinmux_pkg::PS_IDLE && noise_ev &&
		irq_ctl_q[1][pinmux_pkg::IRQ_NOISE_BIT] |=> irq_line[1])
		else $error("noise event did not start pulse");
	engine_source_a: assert property (st_q[1] == pinmux_pkg::PS_IDLE && eng_ev &&
		irq_ctl_q[1][pinmux_pkg::IRQ_ENG_BIT] |=> irq_line[1])
		else $error("engine event did not start pulse");
	data_source_a: assert property (st_q[1] == pinmux_pkg::PS_IDLE && da_ev &&
		irq_ctl_q[1][pinmux_pkg::IRQ_DA_BIT] |=> irq_line[1])
		else $error("data event did not start pulse");
	no_spurious_a: assert property (st_q[1] == pinmux_pkg::PS_IDLE &&
		!(irq_ctl_q[1][pinmux_pkg::IRQ_NOISE_BIT] && noise_ev) &&
		!(irq_ctl_q[1][pinmux_pkg::IRQ_ENG_BIT] && eng_ev) &&
		!(irq_ctl_q[1][pinmux_pkg::IRQ_DA_BIT] && da_ev) |=> !irq_line[1])
		else $error("pulse without enabled event");
	single_pulse_a: assert property ($fell(irq_line[1]) &&
		!irq_ctl_q[1][pinmux_pkg::IRQ_RPT_BIT] |-> st_q[1] == pinmux_pkg::PS_IDLE)
		else $error("single mode pulse repeated");
	repeat_stop_a: assert property (s_flag_read |=> s_repeat_off)
		else $error("repeat pulses survived flag read");
	first_line_a: assert property (st_q[0] == pinmux_pkg::PS_IDLE && da_ev &&
		irq_ctl_q[0][pinmux_pkg::IRQ_DA_BIT] |=> irq_line[0])
		else $error("first line did not start pulse");
	mic_off_a: assert property (mic_q[0][5:2] == pinmux_pkg::MIC_OFF |=>
		!mic_drive[0].in_en && !mic_drive[0].out_en && mic_drive[0].oe_n)
		else $error("disabled mic pin buffers on");
	mic_core_a: assert property (mic_q[1][5:2] == pinmux_pkg::MIC_IN |=>
		mic_core_in[1] == $past(mic_pin_in[1]))
		else $error("core input does not follow pin");
	gpi_sample_a: assert property (mic_q[0][5:2] == pinmux_pkg::MIC_GPI &&
		$stable(mic_q[0]) |=> gpi_q[0] == $past(mic_pin_in[0]))
		else $error("gpi bit does not follow pin");
	mic_gpo_a: assert property (mic_q[1][5:2] == pinmux_pkg::MIC_GPO |=>
		mic_drive[1].out == $past(mic_q[1][pinmux_pkg::GPO_BIT]) && !mic_drive[1].oe_n)
		else $error("mic data gpo level wrong");
	dout_off_a: assert property (dout_q[3:1] == pinmux_pkg::DOUT_OFF |=>
		dout_drive.oe_n && !dout_drive.out_en)
		else $error("disabled serial out pin driven");
	dout_gpo_a: assert property (dout_q[3:1] == pinmux_pkg::DOUT_GPO |=>
		dout_drive.out == $past(dout_q[pinmux_pkg::GPO_BIT]) && !dout_drive.oe_n)
		else $error("serial out gpo level wrong");
	keeper_ctl_a: assert property (##1
		dout_keeper_en == !$past(dout_q[pinmux_pkg::KEEP_BIT]))
		else $error("keeper enable wrong");
	flag_clear_a: assert property (rd_adc && adc_ev == 4'h0 |=> adc_q == 4'h0)
		else $error("flag not cleared by read");
endmodule
`default_nettype wire

//--- pinmux_pkg.sv
// Purpose: shared constants and types for the pin function and interrupt pulse block
// Assumes: 100 MHz clock, byte wide register port with 7 bit addresses
// Notes: pulse times are held in microseconds and turned into cycle counts here
package pinmux_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned PULSE_WIDTH_US = 2000;
	localparam int unsigned PULSE_PERIOD_US = 4000;
	localparam int unsigned PULSE_HIGH_CYC = PULSE_WIDTH_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned PULSE_LOW_CYC =
		(PULSE_PERIOD_US - PULSE_WIDTH_US) * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 18;

	localparam logic [6:0] OFF_FLAG_OVF = 7'h2a;
	localparam logic [6:0] OFF_FLAG_ADC = 7'h2d;
	localparam logic [6:0] OFF_IRQ1_CTL = 7'h30;
	localparam logic [6:0] OFF_IRQ2_CTL = 7'h31;
	localparam logic [6:0] OFF_RSVD = 7'h32;
	localparam logic [6:0] OFF_MIC_CLK = 7'h33;
	localparam logic [6:0] OFF_MIC_DAT = 7'h34;
	localparam logic [6:0] OFF_DOUT = 7'h35;

	localparam logic [7:0] IRQ_CTL_RST = 8'h00;
	localparam logic [7:0] IRQ_CTL_WMASK = 8'h17;
	localparam logic [7:0] MIC_RST = 8'h00;
	localparam logic [7:0] MIC_WMASK = 8'h3d;
	localparam logic [7:0] DOUT_RST = 8'h12;
	localparam logic [7:0] DOUT_WMASK = 8'h1f;

	localparam int unsigned IRQ_NOISE_BIT = 4;
	localparam int unsigned IRQ_ENG_BIT = 2;
	localparam int unsigned IRQ_DA_BIT = 1;
	localparam int unsigned IRQ_RPT_BIT = 0;
	localparam int unsigned MIC_GPI_BIT = 1;
	localparam int unsigned GPO_BIT = 0;
	localparam int unsigned KEEP_BIT = 4;

	typedef enum logic [3:0] {
		MIC_OFF = 4'h0, MIC_IN = 4'h1, MIC_GPI = 4'h2, MIC_GPO = 4'h3,
		MIC_DIVIDED_CLOCK_OUTPUT = 4'h4, MIC_IRQ1 = 4'h5, MIC_IRQ2 = 4'h6,
		MIC_BCLK = 4'h8, MIC_WCLK = 4'h9, MIC_MODCLK = 4'ha
	} mic_code_type;

	typedef enum logic [2:0] {
		DOUT_OFF = 3'h0, DOUT_PRI = 3'h1, DOUT_GPO = 3'h2, DOUT_DIVIDED_CLOCK_OUTPUT = 3'h3,
		DOUT_IRQ1 = 3'h4, DOUT_IRQ2 = 3'h5, DOUT_BCLK = 3'h6, DOUT_WCLK = 3'h7
	} dout_code_type;

	typedef enum logic [2:0] {
		PS_IDLE = 3'b001, PS_HIGH = 3'b010, PS_LOW = 3'b100
	} pulse_state_type;

	typedef struct packed {
		logic ovf_left;
		logic ovf_right;
		logic ovf_shift;
		logic noise_left;
		logic noise_right;
		logic eng_std;
		logic eng_aux;
		logic data_avail;
	} flag_src_type;

	typedef struct packed {
		logic divided_clock_output;
		logic sec_bclk;
		logic sec_wclk;
		logic mod_clk;
		logic pri_dout;
	} out_src_type;

	typedef struct packed {
		logic out;
		logic oe_n;
		logic in_en;
		logic out_en;
	} pin_drive_type;
endpackage

//--- test_multifunction_pin_and_irq2_control.sv
// Purpose: self checking bench for pin functions and pulsed interrupt lines
// Assumes: pulse counts shortened to 8 cycles high and 8 low
// Notes: gpo, keeper and pad levels come from an lfsr
`timescale 1ns/100ps
`default_nettype none
module test_multifunction_pin_and_irq2_control;
	localparam int hc = 8;
	localparam logic [3:0] dmap [8] = '{4'h0, 4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9};
	localparam logic [6:0] ta [6] = '{7'h31, 7'h31, 7'h31, 7'h31, 7'h31, 7'h30};
	localparam logic [7:0] tc [6] = '{8'h02, 8'h00, 8'h10, 8'h04, 8'h02, 8'h02};
	localparam logic [7:0] tm [6] = '{8'h01, 8'h01, 8'h10, 8'h80, 8'h10, 8'h01};
	localparam int tl [6] = '{1, 1, 1, 1, 1, 0};
	logic clock = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dout_keeper_en;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
	logic [1:0] pad = 2'h0, mic_pin_in, mic_core_in, irq_line, irq_q;
	logic [31:0] rnd = 32'h7d224ce1;
	pinmux_pkg::flag_src_type flag_cmd = 8'h00, flag_src;
	pinmux_pkg::out_src_type out_src, src_q;
	pinmux_pkg::pin_drive_type [1:0] mic_drive;
	pinmux_pkg::pin_drive_type dout_drive;
	int err_count = 0, samples_checked = 0, hi;
	initial forever #5 clock = ~clock;
	always @(posedge clock) begin
		src_q <= out_src;
		irq_q <= irq_line;
	end
	multifunction_pin_and_irq2_control #(.pulse_high_cycles(hc), .pulse_low_cycles(hc))
		multifunction_pin_and_irq2_control_inst (.clock(clock), .rstn(rstn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .flag_src(flag_src), .out_src(out_src),
		.mic_pin_in(mic_pin_in), .mic_drive(mic_drive), .mic_core_in(mic_core_in),
		.dout_drive(dout_drive), .dout_keeper_en(dout_keeper_en), .irq_line(irq_line));
	far_side_model far_side_model_inst (.clock(clock), .flag_cmd(flag_cmd), .pad_level(pad),
		.mic_drive(mic_drive), .flag_src(flag_src), .out_src(out_src),
		.mic_pin_in(mic_pin_in));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected {oe_n, in_en, out}, code f stands for primary data
	function automatic logic [2:0] pin_exp(input logic [3:0] c, input logic g);
		case (c)
			4'h1, 4'h2: return 3'b110;
			4'h3: return {2'b00, g};
			4'h4: return {2'b00, src_q.divided_clock_output};
			4'h5: return {2'b00, irq_q[0]};
			4'h6: return {2'b00, irq_q[1]};
			4'h8: return {2'b00, src_q.sec_bclk};
			4'h9: return {2'b00, src_q.sec_wclk};
			4'ha: return {2'b00, src_q.mod_clk};
			4'hf: return {2'b00, src_q.pri_dout};
			default: return 3'b100;
		endcase
	endfunction
	function automatic logic [2:0] got(input pinmux_pkg::pin_drive_type d);
		logic oe_n;
		oe_n = (d.out_en === ~d.oe_n) ? d.oe_n : 1'bx;
		return {oe_n, d.in_en, (d.oe_n === 1'b1) ? 1'b0 : d.out};
	endfunction
	function automatic int exp_hi(input logic [7:0] c, input logic [7:0] m);
		logic en;
		en = (c[1] & m[0]) | (c[4] & |m[4:3]) | (c[2] & (|m[7:5] | |m[2:1]));
		return en ? hc : 0;
	endfunction
	task automatic chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		rd_v = reg_rdata;
	endtask
	task automatic measure(input int ln);
		int n;
		hi = 0;
		n = 0;
		@(negedge clock);
		while (irq_line[ln] !== 1'b1 && n < 12) begin
			@(negedge clock);
			n++;
		end
		while (irq_line[ln] === 1'b1 && hi < 40) begin
			@(negedge clock);
			hi++;
		end
	endtask
	task automatic fire(input logic [7:0] m, input int ln);
		@(posedge clock);
		flag_cmd <= m;
		@(posedge clock);
		flag_cmd <= 8'h00;
		measure(ln);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		logic [3:0] c;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		chk(mic_drive[0].oe_n === 1'b1 && mic_drive[1].oe_n === 1'b1, "mic off");
		chk(got(dout_drive) === pin_exp(4'hf, 1'b0), "serial out reset");
		chk(dout_keeper_en === 1'b0, "keeper reset");
		rd(7'h35);
		chk(rd_v === 8'h12, "serial out reg reset");
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 11; i++) begin
				if (i == 7)
					continue;
				rnd = lfsr(rnd);
				c = i[3:0];
				@(posedge clock);
				pad <= rnd[2:1];
				wr(7'h33 + 7'(p), {2'b00, c, 1'b0, rnd[0]});
				@(posedge clock);
				@(negedge clock);
				chk(got(mic_drive[p]) === pin_exp(c, rnd[0]), "mic drive");
				if (c == 4'h1)
					chk(mic_core_in[p] === pad[p], "core input");
				if (c == 4'h2) begin
					rd(7'h33 + 7'(p));
					chk(rd_v === {2'b00, c, pad[p], rnd[0]}, "input bit");
				end
			end
		end
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(7'h35, {3'b000, rnd[1], i[2:0], rnd[0]});
			@(posedge clock);
			@(negedge clock);
			chk(got(dout_drive) === pin_exp(dmap[i], rnd[0]), "serial out");
			chk(dout_keeper_en === ~rnd[1], "keeper");
		end
		for (int i = 0; i < 6; i++) begin
			wr(ta[i], tc[i]);
			fire(tm[i], tl[i]);
			chk(hi == exp_hi(tc[i], tm[i]), "pulse width");
		end
		rd(7'h30);
		chk(rd_v === 8'h02, "first line control");
		rd(7'h32);
		chk(rd_v === 8'h00, "reserved register");
		rd(7'h2a);
		chk(rd_v === 8'h08, "overflow flag");
		rd(7'h2a);
		chk(rd_v === 8'h00, "overflow cleared");
		rd(7'h2d);
		chk(rd_v === 8'h40, "noise flag");
		wr(7'h31, 8'h03);
		rd(7'h31);
		chk(rd_v === 8'h03, "second line control");
		fire(8'h01, 1);
		chk(hi == hc, "first pulse");
		measure(1);
		chk(hi == hc, "repeated pulse");
		rd(7'h2d);
		repeat (12) @(negedge clock);
		measure(1);
		chk(hi == 0, "repeat stopped");
		results();
	end
endmodule
`default_nettype wire
